// File: dls_params.svh
// offsets, field codes, reset values and timing counts of the drive link supervisor
`ifndef DLS_PARAMS_SVH
`define DLS_PARAMS_SVH

// ************************************************
// register byte offsets
// ************************************************
`define DLS_OFS_MODE     8'h00
`define DLS_OFS_STATION  8'h04
`define DLS_OFS_NODES    8'h08
`define DLS_OFS_LOSS_SEL 8'h0C
`define DLS_OFS_CHECK_MS 8'h10
`define DLS_OFS_TERM_FN  8'h14
`define DLS_OFS_CTRL     8'h18
`define DLS_OFS_STATUS   8'h1C
`define DLS_OFS_SLV_STAT 8'h20
`define DLS_OFS_FAULT    8'h24

// ************************************************
// field codes and reset values
// ************************************************
`define DLS_MODE_BCAST_A 9'h06E
`define DLS_MODE_BCAST_B 9'h06F
`define DLS_TERM_POS     9'h0F2
`define DLS_TERM_NEG     9'h156
`define DLS_FAULT_CODE   8'hE7
`define DLS_LOSS_TRIP    4'h3
`define DLS_STN_MASTER   3'h0
`define DLS_STN_MAX      3'h5
`define DLS_RST_MODE     9'h000
`define DLS_RST_STATION  3'h0
`define DLS_RST_NODES    3'h1
`define DLS_CTRL_RST_BIT 0

// ************************************************
// timing
// ************************************************
`define DLS_CLK_MHZ          20
`define DLS_BCAST_PERIOD_US  3000
`define DLS_MS_US            1000
`define DLS_SLAVE_TIMEOUT_US 9000
`define DLS_CNT_W            18

`endif

// File: dls_pkg.sv
// types shared by the drive link supervisor
package dls_pkg;

    // the four control quantities carried by each broadcast
    typedef struct packed {
        logic [15:0]        torque_cur;
        logic [15:0]        speed_cmd;
        logic [15:0]        position;
        logic signed [15:0] actual_speed;
    } dls_qty_t;

    // link settings that only take effect at a drive reset
    typedef struct packed {
        logic [8:0] mode;
        logic [2:0] station;
        logic [2:0] nodes;
    } dls_cfg_t;

    typedef enum logic [1:0] {ST_OFF, ST_INIT, ST_UP} dls_state_t;

endpackage

// File: dls_timer.sv
// free running divider that gives a one-cycle pulse every LIMIT cycles
`timescale 1ns/1ps
`include "dls_params.svh"
module dls_timer
    import dls_pkg::*;
#(
    parameter int unsigned LIMIT = 60000
)
(
    input  wire logic sys_clk,
    input  wire logic rst,
    input  wire logic run,
    input  wire logic restart,
    output logic      done
);

    logic [`DLS_CNT_W-1:0] cnt;
    wire                   wrap = (cnt == `DLS_CNT_W'(LIMIT - 1));

    // restart holds the count at zero, so a steady restart never fires
    always_ff @(posedge sys_clk)
    begin
        if (rst || !run || restart)
        begin
            cnt  <= '0;
            done <= 1'b0;
        end
        else
        begin
            done <= wrap;
            cnt  <= wrap ? '0 : cnt + `DLS_CNT_W'(1);
        end
    end

endmodule // dls_timer

// File: dls_supervisor.sv
// drive link supervisor: broadcast link master/slave, link flag and fault trip
`timescale 1ns/1ps
`include "dls_params.svh"
module dls_supervisor
    import dls_pkg::*;
#(
    parameter int unsigned BCAST_CYCLES = `DLS_BCAST_PERIOD_US * `DLS_CLK_MHZ,
    parameter int unsigned MS_CYCLES    = `DLS_MS_US * `DLS_CLK_MHZ,
    parameter int unsigned SLAVE_TO_CYC = `DLS_SLAVE_TIMEOUT_US * `DLS_CLK_MHZ
)
(
    input  wire logic        sys_clk,
    input  wire logic        rst,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    input  wire logic        start_cmd_pin,
    input  wire logic        phy_loss_pin,
    input  wire logic        cmd_src_alive,
    input  wire dls_qty_t    local_qty,
    input  wire logic        rx_req,
    input  wire dls_qty_t    rx_qty,
    input  wire logic        rx_resp_valid,
    input  wire logic [2:0]  rx_resp_station,
    output logic             tx_bcast,
    output dls_qty_t         tx_qty,
    output logic             tx_resp,
    output dls_qty_t         slave_qty,
    output logic             link_up_flag,
    output logic             link_term,
    output logic             comm_fault_trip
);

    // ************************************************
    // helpers
    // ************************************************
    // byte-lane merge of a write into a stored value
    function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] nw,
                                           input logic [3:0] sel);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++)
            if (sel[i]) r[8*i +: 8] = nw[8*i +: 8];
        return r;
    endfunction

    // one-hot slave bit for station 1..5, zero otherwise
    function automatic logic [4:0] stn_bit(input logic [2:0] stn);
        logic [4:0] r;
        r = 5'h00;
        if (stn != 3'h0 && stn <= `DLS_STN_MAX) r[stn - 3'h1] = 1'b1;
        return r;
    endfunction

    // ************************************************
    // register bus
    // ************************************************
    logic [8:0]  reg_mode;
    logic [2:0]  reg_station;
    logic [2:0]  reg_nodes;
    logic [3:0]  reg_loss_sel;
    logic [15:0] reg_check_ms;
    logic [8:0]  reg_term_fn;
    logic        soft_rst;
    logic [4:0]  slv_status;
    logic        started;
    dls_cfg_t    eff;
    dls_state_t  state;
    dls_state_t  next_state;

    wire       wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    wire       wb_wr  = wb_req & wb_we_i;
    wire [7:0] adr_w  = {wb_adr_i[7:2], 2'b00};
    wire       en     = (eff.mode == `DLS_MODE_BCAST_A) || (eff.mode == `DLS_MODE_BCAST_B);
    wire       master = en && (eff.station == `DLS_STN_MASTER);
    wire       slave  = en && (eff.station != `DLS_STN_MASTER) && (eff.station <= `DLS_STN_MAX);
    wire [7:0] fault_code = comm_fault_trip ? `DLS_FAULT_CODE : 8'h00;

    // read mux; unmapped offsets read zero and ignore writes
    logic [31:0] rdata;
    always_comb
    begin
        case (adr_w)
            `DLS_OFS_MODE:     rdata = {23'h0, reg_mode};
            `DLS_OFS_STATION:  rdata = {29'h0, reg_station};
            `DLS_OFS_NODES:    rdata = {29'h0, reg_nodes};
            `DLS_OFS_LOSS_SEL: rdata = {28'h0, reg_loss_sel};
            `DLS_OFS_CHECK_MS: rdata = {16'h0, reg_check_ms};
            `DLS_OFS_TERM_FN:  rdata = {23'h0, reg_term_fn};
            `DLS_OFS_STATUS:   rdata = {27'h0, master, en, started, comm_fault_trip, link_up_flag};
            `DLS_OFS_SLV_STAT: rdata = {27'h0, slv_status};
            `DLS_OFS_FAULT:    rdata = {24'h0, fault_code};
            default:           rdata = 32'h0000_0000;
        endcase
    end

    // write value: byte lanes merged over the addressed register's current contents
    wire [31:0] wr_val = wmerge(rdata, wb_dat_i, wb_sel_i);

    // single-wait-state answer: ack one cycle after the request is seen
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end
        else
        begin
            wb_ack_o <= wb_req;
            if (wb_req) wb_dat_o <= rdata;
        end
    end

    // staged settings; software writes here, the link sees mode, station and nodes only at a reset
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            reg_mode     <= `DLS_RST_MODE;
            reg_station  <= `DLS_RST_STATION;
            reg_nodes    <= `DLS_RST_NODES;
            reg_loss_sel <= 4'h0;
            reg_check_ms <= 16'h0000;
            reg_term_fn  <= 9'h000;
            soft_rst     <= 1'b0;
        end
        else
        begin
            soft_rst <= wb_wr && adr_w == `DLS_OFS_CTRL && wb_sel_i[0]
                        && wb_dat_i[`DLS_CTRL_RST_BIT];
            if (wb_wr)
            begin
                case (adr_w)
                    `DLS_OFS_MODE:     reg_mode     <= wr_val[8:0];
                    `DLS_OFS_STATION:  reg_station  <= wr_val[2:0];
                    `DLS_OFS_NODES:    reg_nodes    <= wr_val[2:0];
                    `DLS_OFS_LOSS_SEL: reg_loss_sel <= wr_val[3:0];
                    `DLS_OFS_CHECK_MS: reg_check_ms <= wr_val[15:0];
                    `DLS_OFS_TERM_FN:  reg_term_fn  <= wr_val[8:0];
                    default:           ;
                endcase
            end
        end
    end

    // effective link settings; a drive reset copies the staged values across
    always_ff @(posedge sys_clk)
    begin
        if (rst)
            eff <= '{mode: `DLS_RST_MODE, station: `DLS_RST_STATION, nodes: `DLS_RST_NODES};
        else if (soft_rst)
            eff <= '{mode: reg_mode, station: reg_station, nodes: reg_nodes};
    end

    // ************************************************
    // pin synchronisers
    // ************************************************
    logic start_m, start_s, start_d, loss_m, loss_s;

    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            {start_m, start_s, start_d} <= 3'b000;
            {loss_m, loss_s}            <= 2'b00;
        end
        else
        begin
            {start_m, start_s, start_d} <= {start_cmd_pin, start_m, start_s};
            {loss_m, loss_s}            <= {phy_loss_pin, loss_m};
        end
    end

    wire start_rise = start_s & ~start_d;

    // ************************************************
    // timers
    // ************************************************
    logic period_tick, ms_tick, wd_done;

    // master broadcast period, transmission delay counted inside it
    dls_timer #(.LIMIT(BCAST_CYCLES)) u_period (
        .sys_clk (sys_clk),
        .rst     (rst | soft_rst),
        .run     (master),
        .restart (1'b0),
        .done    (period_tick)
    );

    dls_timer #(.LIMIT(MS_CYCLES)) u_ms (
        .sys_clk (sys_clk),
        .rst     (rst),
        .run     (1'b1),
        .restart (1'b0),
        .done    (ms_tick)
    );

    // slave request watchdog, restarted by every request
    dls_timer #(.LIMIT(SLAVE_TO_CYC)) u_wd (
        .sys_clk (sys_clk),
        .rst     (rst | soft_rst),
        .run     (slave),
        .restart (rx_req),
        .done    (wd_done)
    );

    // ************************************************
    // link state
    // ************************************************
    logic [4:0] answered;
    wire  [4:0] exp_mask = 5'(((7'h01 << eff.nodes) - 7'h01) >> 1);
    wire  [4:0] new_ans  = rx_resp_valid ? stn_bit(rx_resp_station) : 5'h00;
    wire  [4:0] got      = (answered | new_ans) & exp_mask;
    wire        all_ans  = (got == exp_mask);
    wire        req_ok   = slave & rx_req & ~loss_s;

    always_comb
    begin
        next_state = state;
        case (state)
            ST_OFF:
                if (req_ok)
                    next_state = ST_UP;
                else if (master || slave)
                    next_state = ST_INIT;
            ST_INIT:
                if (loss_s)
                    next_state = ST_INIT;
                else if (master && period_tick && all_ans)
                    next_state = ST_UP;
                else if (req_ok)
                    next_state = ST_UP;
            ST_UP:
                if (loss_s || (master && period_tick && !all_ans) || (slave && wd_done && !req_ok))
                    next_state = ST_INIT;
            default: next_state = ST_OFF;
        endcase
        if (!(master || slave)) next_state = ST_OFF;
    end

    // answers in the tick cycle still count for the closing period
    always_ff @(posedge sys_clk)
    begin
        if (rst || soft_rst)
        begin
            state        <= ST_OFF;
            link_up_flag <= 1'b0;
            answered     <= 5'h00;
            slv_status   <= 5'h00;
        end
        else
        begin
            state        <= next_state;
            link_up_flag <= (next_state == ST_UP);
            answered     <= period_tick ? 5'h00 : (answered | new_ans);
            if (master && period_tick)
                slv_status <= got;
            else if (slave)
                slv_status <= stn_bit(eff.station) & {5{next_state == ST_UP}};
        end
    end

    // broadcast and response traffic with the four quantities
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            tx_bcast  <= 1'b0;
            tx_resp   <= 1'b0;
            tx_qty    <= '0;
            slave_qty <= '0;
        end
        else
        begin
            tx_bcast <= master & period_tick;
            tx_resp  <= req_ok;
            if (master && period_tick)
                tx_qty <= local_qty;
            if (req_ok)
                slave_qty <= rx_qty;
        end
    end

    // terminal copy of the flag, polarity picked by the function code
    always_ff @(posedge sys_clk)
    begin
        if (rst)
            link_term <= 1'b0;
        else if (reg_term_fn == `DLS_TERM_POS)
            link_term <= link_up_flag;
        else if (reg_term_fn == `DLS_TERM_NEG)
            link_term <= ~link_up_flag;
        else
            link_term <= 1'b0;
    end

    // ************************************************
    // fault trip
    // ************************************************
    logic        link_prev;
    logic [15:0] silent_ms;

    wire fell_trip  = en & started & link_prev & ~link_up_flag;
    wire first_trip = en & ~started & start_rise & ~link_up_flag;
    wire loss_trip  = (reg_loss_sel == `DLS_LOSS_TRIP) & loss_s;
    wire quiet_trip = (reg_check_ms != 16'h0000) & (silent_ms >= reg_check_ms);

    // silence counter saturates so a long outage cannot wrap back to zero
    always_ff @(posedge sys_clk)
    begin
        if (rst || cmd_src_alive)
            silent_ms <= 16'h0000;
        else if (ms_tick && silent_ms != 16'hFFFF)
            silent_ms <= silent_ms + 16'h0001;
    end

    // trip latches until a reset; the flag drop is checked only once started, and the first start trips if the flag is not up
    always_ff @(posedge sys_clk)
    begin
        if (rst || soft_rst)
        begin
            started         <= 1'b0;
            link_prev       <= 1'b0;
            comm_fault_trip <= 1'b0;
        end
        else
        begin
            link_prev <= link_up_flag;
            if (start_rise)
                started <= 1'b1;
            if (fell_trip || first_trip || loss_trip || quiet_trip)
                comm_fault_trip <= 1'b1;
        end
    end

    // ************************************************
    // checks
    // ************************************************
    logic [`DLS_CNT_W-1:0] gap;
    logic                  gap_seen;

    always_ff @(posedge sys_clk)
    begin
        if (rst || soft_rst)
        begin
            gap      <= '0;
            gap_seen <= 1'b0;
        end
        else
        begin
            gap      <= tx_bcast ? '0 : gap + `DLS_CNT_W'(1);
            gap_seen <= gap_seen | tx_bcast;
        end
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    ack_one_shot_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held more than one cycle");
    bcast_period_a: assert property (tx_bcast && gap_seen
                                     |-> gap == `DLS_CNT_W'(BCAST_CYCLES - 1))
        else $error("broadcast period wrong");
    bcast_master_a: assert property (tx_bcast |-> $past(master))
        else $error("broadcast from non-master");
    link_enable_a: assert property (!en |=> !link_up_flag)
        else $error("link up while disabled");
    slave_answer_a: assert property (req_ok && !soft_rst |=> tx_resp && link_up_flag)
        else $error("slave did not answer");
    loss_drop_a: assert property (loss_s && !soft_rst |=> !link_up_flag)
        else $error("flag held through signal loss");
    first_start_a: assert property (first_trip && !soft_rst |=> comm_fault_trip)
        else $error("first start trip missing");
    flag_fall_a: assert property (en && started && $fell(link_up_flag) && !soft_rst
                                  |=> comm_fault_trip)
        else $error("flag fall trip missing");
    trip_latch_a: assert property (comm_fault_trip && !soft_rst |=> comm_fault_trip)
        else $error("trip released without reset");
    term_pos_a: assert property ($past(reg_term_fn) == `DLS_TERM_POS
                                 |-> link_term == $past(link_up_flag))
        else $error("terminal polarity wrong");

    link_up_c:  cover property ($rose(link_up_flag));
    trip_c:     cover property ($rose(comm_fault_trip));
    bcast_c:    cover property (tx_bcast ##[1:8] rx_resp_valid);
    slv_resp_c: cover property (tx_resp);

endmodule // dls_supervisor

// File: dls_peer.sv
// peer drive model at the far end of the broadcast link
`timescale 1ns/1ps
module dls_peer
    import dls_pkg::*;
(
    input  wire logic       sys_clk,
    input  wire logic       rst,
    input  wire logic       tx_bcast,
    input  wire logic [4:0] resp_mask,
    input  wire logic       req_en,
    output logic            rx_req,
    output dls_qty_t        rx_qty,
    output logic            rx_resp_valid,
    output logic [2:0]      rx_resp_station
);
    logic [4:0]  pend;
    logic [5:0]  cnt;
    logic [11:0] nreq;
    logic [2:0]  low;

    // lowest pending slave answers first; stations are unique and consecutive
    assign low = pend[0] ? 3'h1 : pend[1] ? 3'h2 : pend[2] ? 3'h3 : pend[3] ? 3'h4 : 3'h5;

    // full duplex path through one hub, so answers come one a cycle
    always_ff @(posedge sys_clk)
    begin
        rx_resp_valid   <= 1'b0;
        rx_req          <= 1'b0;
        rx_resp_station <= ~rx_resp_station; // idle lines must not hold stale values
        rx_qty          <= ~rx_qty;
        cnt             <= cnt + 6'h01;
        if (tx_bcast)
            pend <= resp_mask;
        else if (pend != 5'h00)
        begin
            rx_resp_valid   <= 1'b1;
            rx_resp_station <= low;
            pend            <= pend & (pend - 5'h01);
        end
        if (req_en && cnt == 6'h00)
        begin
            rx_req <= 1'b1;
            rx_qty <= {4{4'hA, nreq}};
            nreq   <= nreq + 12'h001;
        end
        if (rst)
        begin
            pend            <= 5'h00;
            cnt             <= 6'h00;
            nreq            <= 12'h000;
            rx_qty          <= '0;
            rx_resp_station <= 3'h0;
        end
    end
endmodule // dls_peer

// File: tb_dls_supervisor.sv
// self-checking bench for the drive link supervisor
`timescale 1ns/1ps
`include "dls_params.svh"
module tb_dls_supervisor
    import dls_pkg::*;
;
    logic        sys_clk, rst, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
    logic [7:0]  wb_adr_i;
    logic [3:0]  wb_sel_i;
    logic [31:0] wb_dat_i, wb_dat_o;
    logic        start_cmd_pin, phy_loss_pin, cmd_src_alive, req_en, rx_req;
    logic        rx_resp_valid, tx_bcast, tx_resp, link_up_flag, link_term, comm_fault_trip;
    logic [2:0]  rx_resp_station;
    logic [4:0]  resp_mask;
    dls_qty_t    local_qty, rx_qty, tx_qty, slave_qty;
    int          errors, samples_checked;

    // short counts keep the run brief
    dls_supervisor #(.BCAST_CYCLES(40), .MS_CYCLES(10), .SLAVE_TO_CYC(150)) i_dls_supervisor
    (
        .sys_clk, .rst, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
        .wb_dat_o, .wb_ack_o, .start_cmd_pin, .phy_loss_pin, .cmd_src_alive, .local_qty,
        .rx_req, .rx_qty, .rx_resp_valid, .rx_resp_station, .tx_bcast, .tx_qty, .tx_resp,
        .slave_qty, .link_up_flag, .link_term, .comm_fault_trip
    );
    dls_peer i_dls_peer
    (
        .sys_clk, .rst, .tx_bcast, .resp_mask, .req_en, .rx_req, .rx_qty, .rx_resp_valid,
        .rx_resp_station
    );

    // 50 ns clock
    initial
    begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end

    // ****
    // bench tasks
    // ****
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            errors++;
            $display("CHECK FAILED %0t ns: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
    endtask

    // classic cycle: hold until ack is sampled, then release for a cycle
    task automatic wb_go(input logic [7:0] a, input logic w, input logic [31:0] d,
                         output logic [31:0] q);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= w;
        wb_sel_i <= 4'hF;
        wb_adr_i <= a;
        wb_dat_i <= d;
        @(posedge sys_clk);
        while (wb_ack_o !== 1'b1)
            @(posedge sys_clk);
        q = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        @(posedge sys_clk);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        wb_go(a, 1'b1, d, q);
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] q;
        wb_go(a, 1'b0, 32'h0, q);
        chk(q, e);
    endtask

    // bounded wait, the flag timing depends on the broadcast period
    task automatic wait_flag(input logic v);
        for (int i = 0; i < 300 && link_up_flag !== v; i++)
            @(posedge sys_clk);
        chk(link_up_flag, v);
    endtask

    task automatic wait_bcast(output int n);
        n = 0;
        do
        begin
            @(posedge sys_clk);
            n++;
        end
        while (tx_bcast !== 1'b1 && n < 200);
    endtask

    task automatic soft_rst;
        wr(`DLS_OFS_CTRL, 32'h1);
        tick(2);
    endtask

    // ****
    // scenarios
    // ****
    task automatic t_reset;
        rd_chk(`DLS_OFS_NODES, 32'h1);
        rd_chk(8'h3C, 32'h0);
        start_cmd_pin <= 1'b1;
        tick(8);
        chk(comm_fault_trip, 1'b0);
        start_cmd_pin <= 1'b0;
    endtask

    // station 3 also answers but lies beyond the node count
    task automatic t_master;
        int n;
        resp_mask <= 5'h07;
        wr(`DLS_OFS_MODE, {23'h0, `DLS_MODE_BCAST_A});
        wr(`DLS_OFS_NODES, 32'h3);
        rd_chk(`DLS_OFS_STATUS, 32'h04);
        soft_rst;
        rd_chk(`DLS_OFS_STATUS, 32'h18);
        wait_bcast(n);
        chk(tx_qty, local_qty);
        local_qty <= 64'h0F0F_1234_8000_7FFF;
        wait_bcast(n);
        chk(n, 40);
        chk(tx_qty, 64'h0F0F_1234_8000_7FFF);
        wait_flag(1'b1);
        rd_chk(`DLS_OFS_SLV_STAT, 32'h3);
        wr(`DLS_OFS_TERM_FN, {23'h0, `DLS_TERM_POS});
        chk(link_term, 1'b1);
        wr(`DLS_OFS_TERM_FN, 32'h0F1);
        chk(link_term, 1'b0);
        wr(`DLS_OFS_TERM_FN, {23'h0, `DLS_TERM_NEG});
        chk(link_term, 1'b0);
    endtask

    task automatic t_flag_fall;
        start_cmd_pin <= 1'b1;
        tick(8);
        chk(comm_fault_trip, 1'b0);
        start_cmd_pin <= 1'b0;
        tick(8);
        resp_mask <= 5'h05;
        wait_flag(1'b0);
        tick(2);
        chk(link_term, 1'b1);
        chk(comm_fault_trip, 1'b1);
        rd_chk(`DLS_OFS_FAULT, 32'hE7);
        resp_mask <= 5'h07;
        tick(100);
        chk(comm_fault_trip, 1'b1);
    endtask

    task automatic t_first_start;
        soft_rst;
        chk(comm_fault_trip, 1'b0);
        start_cmd_pin <= 1'b1;
        tick(8);
        chk(comm_fault_trip, 1'b1);
        start_cmd_pin <= 1'b0;
    endtask

    task automatic t_loss;
        soft_rst;
        wait_flag(1'b1);
        phy_loss_pin <= 1'b1;
        tick(6);
        chk(link_up_flag, 1'b0);
        chk(comm_fault_trip, 1'b0);
        wr(`DLS_OFS_LOSS_SEL, 32'h3);
        tick(2);
        chk(comm_fault_trip, 1'b1);
        phy_loss_pin <= 1'b0;
    endtask

    task automatic t_silence;
        wr(`DLS_OFS_LOSS_SEL, 32'h0);
        wr(`DLS_OFS_CHECK_MS, 32'h2);
        soft_rst;
        cmd_src_alive <= 1'b0;
        tick(8);
        chk(comm_fault_trip, 1'b0);
        tick(30);
        chk(comm_fault_trip, 1'b1);
        cmd_src_alive <= 1'b1;
        wr(`DLS_OFS_CHECK_MS, 32'h0);
    endtask

    task automatic t_slave;
        logic [63:0] q;
        wr(`DLS_OFS_MODE, {23'h0, `DLS_MODE_BCAST_B});
        wr(`DLS_OFS_STATION, 32'h2);
        soft_rst;
        rd_chk(`DLS_OFS_STATUS, 32'h08);
        req_en <= 1'b1;
        for (int i = 0; i < 100 && rx_req !== 1'b1; i++)
            @(posedge sys_clk);
        q = rx_qty;
        req_en <= 1'b0;
        @(posedge sys_clk);
        chk(tx_resp, 1'b1);
        chk(link_up_flag, 1'b1);
        chk(slave_qty, q);
        tick(140);
        chk(link_up_flag, 1'b1);
        tick(20);
        chk(link_up_flag, 1'b0);
    endtask

    task automatic finish_test;
        $display("comparisons %0d, mismatches %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // a hang counts as a mismatch
    initial
    begin
        #(20000 * 50);
        errors++;
        finish_test;
    end

    initial
    begin
        rst = 1'b1;
        wb_cyc_i = 1'b0;
        wb_stb_i = 1'b0;
        wb_we_i = 1'b0;
        wb_adr_i = 8'h00;
        wb_sel_i = 4'hF;
        wb_dat_i = 32'h0;
        start_cmd_pin = 1'b0;
        phy_loss_pin = 1'b0;
        cmd_src_alive = 1'b1;
        req_en = 1'b0;
        resp_mask = 5'h00;
        local_qty = 64'h1234_5678_9ABC_DEF0;
        errors = 0;
        samples_checked = 0;
        tick(10);
        rst <= 1'b0;
        @(posedge sys_clk);
        t_reset;
        t_master;
        t_flag_fall;
        t_first_start;
        t_loss;
        t_silence;
        t_slave;
        finish_test;
    end
endmodule // tb_dls_supervisor
